// file: fid_params.svh
// Constants of the Flash instruction decoder: codes, addresses, timing.
// Assumes a 40 MHz core clock; included by the package and the decoder.
`ifndef FID_PARAMS_SVH
`define FID_PARAMS_SVH

`define FID_ADDR_W        16
`define FID_DATA_W        16
`define FID_MATCH_W       12
`define FID_PRIM_N        8
`define FID_SEC_N         4

`define FID_UNLOCK1_ADDR  12'haaa
`define FID_UNLOCK2_ADDR  12'h554
`define FID_UNLOCK1_DATA  8'haa
`define FID_UNLOCK2_DATA  8'h55
`define FID_CMD_ID        8'h90
`define FID_CMD_PROG      8'ha0
`define FID_CMD_ERASE     8'h80
`define FID_CMD_BYPASS    8'h20
`define FID_CMD_SECTOR    8'h30
`define FID_CMD_BULK      8'h10
`define FID_CMD_SUSPEND   8'hb0
`define FID_CMD_RESUME    8'h30
`define FID_CMD_RESET     8'hf0
`define FID_CMD_BYP_EXIT  8'h00

`define FID_RD_ID_ADDR    8'h02
`define FID_RD_PROT_ADDR  8'h04
`define FID_PROT_YES      16'h0001
`define FID_PROT_NO       16'h0000

`define FID_CLK_NS        25
`define FID_ERASE_WIN_NS  80000
`define FID_ERASE_WIN_CYC (`FID_ERASE_WIN_NS / `FID_CLK_NS)
`define FID_TIMEOUT_CYC   4000

`endif

// file: fid_pkg.sv
// Types of the Flash instruction decoder.
// Assumes fid_params.svh for field widths.
`include "fid_params.svh"
package fid_pkg;

    typedef enum logic [3:0] {
        ST_READ  = 4'h0,
        ST_U1    = 4'h1,
        ST_U2    = 4'h3,
        ST_ID    = 4'h2,
        ST_PROG  = 4'h6,
        ST_EU0   = 4'h7,
        ST_EU1   = 4'h5,
        ST_ECMD  = 4'h4,
        ST_EADD  = 4'hc,
        ST_BYP   = 4'hd,
        ST_BPROG = 4'hf,
        ST_BRST  = 4'he,
        ST_ERR   = 4'ha
    } fid_state_t;

    typedef struct packed {
        logic                     wr_n;
        logic                     rd_n;
        logic [`FID_ADDR_W-1:0]   addr;
        logic [`FID_DATA_W-1:0]   data;
        logic [`FID_PRIM_N-1:0]   primary_sector_select;
        logic [`FID_SEC_N-1:0]    secondary_sector_select;
    } fid_pins_t;

    typedef struct packed {
        logic                     prog_start;
        logic                     erase_sector;
        logic                     erase_bulk;
        logic                     suspend;
        logic                     resume;
        logic                     to_secondary;
        logic [`FID_PRIM_N-1:0]   primary_sector_select;
        logic [`FID_SEC_N-1:0]    secondary_sector_select;
        logic [`FID_ADDR_W-1:0]   program_target_address;
        logic [`FID_DATA_W-1:0]   program_word_value;
    } fid_cmd_t;

endpackage : fid_pkg

// file: fid_timer.sv
// Restartable cycle timer: one-cycle expiry pulse after LIMIT cycles.
// Assumes restart and run come from logic on core_clk.
module fid_timer #(
    parameter int W     = 16,
    parameter int LIMIT = 4000
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Control
    input  wire logic restart,
    input  wire logic run,
    // Status
    output logic      expired
);
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         exp_reg;
    logic         exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (restart || !run) begin
            cnt_next = '0;
        end else if (cnt_reg == LAST) begin
            exp_next = 1'b1;
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign expired = exp_reg;

endmodule : fid_timer

// file: fid_decoder.sv
// Flash instruction decoder: turns bus write sequences into array commands.
// Assumes the array answers array_rd_data for the synchronised address.
`include "fid_params.svh"

// Behaviour
// RULE1: Written bytes decode instructions, never stored directly.
// RULE2: Execute only after full count, gaps within timeout.
// RULE3: Invalid byte or timeout returns to read array; in bypass mode the code returns to bypass instead.
// RULE4: Read-array mode reads return array contents.
// RULE5: Unlock needs AAh at AAAh, then 55h at 554h.
// RULE6: Address bits 15..12 ignored; sector select required.
// RULE7: Sector selects route instruction to primary or secondary.
// RULE8: Third write at AAAh: 90h, A0h, 80h, 20h.
// RULE9: ID read at 02h, primary array only.
// RULE10: Protection read at 04h gives 01h or 00h.
// RULE11: Program data word; erase 30h sector, 10h bulk.
// RULE12: B0h suspends erase; 30h resumes suspended erase.
// RULE13: F0h at any address returns to read array; in bypass mode the code stays in bypass instead.
// RULE14: Bypass: A0h then data programs; 90h,00h exits.
// RULE15: Only address bits 11..0 are matched.
// RULE16: Extra erase sectors accepted within 80 us.
// RULE17: ID, protection or error held until reset command.
// RULE18: Inter-byte timeout is a restartable cycle count.
module fid_decoder
    import fid_pkg::*;
#(
    parameter int          TIMEOUT_CYC   = `FID_TIMEOUT_CYC,
    parameter int          ERASE_WIN_CYC = `FID_ERASE_WIN_CYC,
    parameter logic [15:0] ID_VALUE      = 16'h005a  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // Bus pins
    input  wire fid_pins_t              bus_pins,
    // Array side
    input  wire logic [`FID_DATA_W-1:0] array_rd_data,
    input  wire logic [11:0]            sector_protect,
    input  wire logic                   erase_busy,
    input  wire logic                   err_flag,
    // Results
    output fid_cmd_t                    cmd,
    output logic [`FID_DATA_W-1:0]      rd_data,
    output logic                        rd_valid,
    output logic                        read_array_mode,
    output logic                        bypass_mode
);
    fid_pins_t                sync1_reg;
    fid_pins_t                sync2_reg;
    logic                     wr_prev_reg;
    logic                     rd_prev_reg;
    fid_state_t               st_reg;
    fid_state_t               st_next;
    logic                     susp_reg;
    logic                     susp_next;
    fid_cmd_t                 cmd_reg;
    fid_cmd_t                 cmd_next;
    logic [`FID_DATA_W-1:0]   rd_data_reg;
    logic [`FID_DATA_W-1:0]   rd_data_next;
    logic                     rd_valid_reg;
    logic                     mode_reg;
    logic                     byp_reg;
    logic                     sel_prim;
    logic                     sel_sec;
    logic                     wr_go;
    logic                     rd_go;
    logic [`FID_MATCH_W-1:0]  lo_addr;
    logic [7:0]               dbyte;
    logic                     tmo_exp;
    logic                     win_exp;
    logic                     win_restart;

    function automatic logic pending(input fid_state_t s);
        return s inside {ST_U1, ST_U2, ST_PROG, ST_EU0, ST_EU1, ST_ECMD,
                         ST_BPROG, ST_BRST};
    endfunction : pending

    function automatic logic hit(input logic [`FID_MATCH_W-1:0] a,
                                 input logic [7:0] d,
                                 input logic [`FID_MATCH_W-1:0] ea,
                                 input logic [7:0] ed);
        return (a == ea) && (d == ed);
    endfunction : hit

    // Pin synchroniser, strobe history reads stage two only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_reg   <= '1;
            sync2_reg   <= '1;
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
        end else begin
            sync1_reg   <= bus_pins;
            sync2_reg   <= sync1_reg;
            wr_prev_reg <= sync2_reg.wr_n;
            rd_prev_reg <= sync2_reg.rd_n;
        end
    end

    // Flash addressed only with a sector select active
    assign sel_prim = |sync2_reg.primary_sector_select;           // [RULE7]
    assign sel_sec  = |sync2_reg.secondary_sector_select;         // [RULE7]
    assign wr_go    = wr_prev_reg && !sync2_reg.wr_n
                      && (sel_prim || sel_sec);                   // [RULE6]
    assign rd_go    = rd_prev_reg && !sync2_reg.rd_n
                      && (sel_prim || sel_sec);
    assign lo_addr  = sync2_reg.addr[`FID_MATCH_W-1:0];      // [RULE15] [RULE6]
    assign dbyte    = sync2_reg.data[7:0];

    // Inter-byte timeout restarts on every accepted write
    fid_timer #(
        .W     (16),
        .LIMIT (TIMEOUT_CYC)
    ) u_gap_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .restart  (wr_go),                                        // [RULE18]
        .run      (pending(st_reg)),
        .expired  (tmo_exp)
    );

    // Window for further sector erase writes
    assign win_restart = wr_go && dbyte == `FID_CMD_SECTOR;
    fid_timer #(
        .W     (16),
        .LIMIT (ERASE_WIN_CYC)
    ) u_erase_window (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .restart  (win_restart),                                  // [RULE16]
        .run      (st_reg == ST_EADD),
        .expired  (win_exp)
    );

    // Instruction sequencer
    always_comb begin
        st_next   = st_reg;
        susp_next = susp_reg;
        cmd_next  = cmd_reg;
        cmd_next.prog_start   = 1'b0;
        cmd_next.erase_sector = 1'b0;
        cmd_next.erase_bulk   = 1'b0;
        cmd_next.suspend      = 1'b0;
        cmd_next.resume       = 1'b0;
        if (wr_go) begin
            cmd_next.to_secondary = !sel_prim;                    // [RULE7]
            cmd_next.primary_sector_select =
                sync2_reg.primary_sector_select;
            cmd_next.secondary_sector_select =
                sync2_reg.secondary_sector_select;
        end
        if (err_flag && st_reg != ST_ERR) begin
            st_next = ST_ERR;                                     // [RULE17]
        end else if (tmo_exp && pending(st_reg)) begin
            st_next = byp_reg ? ST_BYP : ST_READ;         // [RULE2] [RULE3]
        end else if (win_exp && st_reg == ST_EADD) begin
            st_next = ST_READ;                                    // [RULE16]
        end else if (wr_go) begin                                 // [RULE1]
            unique case (st_reg)
                ST_READ: begin
                    if (hit(lo_addr, dbyte, `FID_UNLOCK1_ADDR,
                            `FID_UNLOCK1_DATA)) begin
                        st_next = ST_U1;                          // [RULE5]
                    end else if (dbyte == `FID_CMD_SUSPEND
                                 && erase_busy && !susp_reg) begin
                        cmd_next.suspend = 1'b1;                  // [RULE12]
                        susp_next        = 1'b1;
                    end else if (dbyte == `FID_CMD_RESUME
                                 && susp_reg) begin
                        cmd_next.resume = 1'b1;                   // [RULE12]
                        susp_next       = 1'b0;
                    end
                end
                ST_U1: begin
                    st_next = hit(lo_addr, dbyte, `FID_UNLOCK2_ADDR,
                                  `FID_UNLOCK2_DATA) ? ST_U2 : ST_READ;
                end
                ST_U2: begin
                    st_next = ST_READ;                            // [RULE3]
                    if (lo_addr == `FID_UNLOCK1_ADDR) begin
                        unique case (dbyte)                       // [RULE8]
                            `FID_CMD_ID:     st_next = ST_ID;
                            `FID_CMD_PROG:   st_next = ST_PROG;
                            `FID_CMD_ERASE:  st_next = ST_EU0;
                            `FID_CMD_BYPASS: st_next = ST_BYP;
                            default:         st_next = ST_READ;
                        endcase
                    end
                end
                ST_ID, ST_ERR: begin
                    if (dbyte == `FID_CMD_RESET) begin
                        st_next = ST_READ;                   // [RULE13] [RULE17]
                    end
                end
                ST_PROG, ST_BPROG: begin
                    cmd_next.prog_start = 1'b1;                   // [RULE11]
                    cmd_next.program_target_address = sync2_reg.addr;
                    cmd_next.program_word_value     = sync2_reg.data;
                    st_next = (st_reg == ST_BPROG) ? ST_BYP : ST_READ;
                end
                ST_EU0: begin
                    st_next = hit(lo_addr, dbyte, `FID_UNLOCK1_ADDR,
                                  `FID_UNLOCK1_DATA) ? ST_EU1 : ST_READ;
                end
                ST_EU1: begin
                    st_next = hit(lo_addr, dbyte, `FID_UNLOCK2_ADDR,
                                  `FID_UNLOCK2_DATA) ? ST_ECMD : ST_READ;
                end
                ST_ECMD, ST_EADD: begin
                    st_next = ST_READ;
                    if (dbyte == `FID_CMD_SECTOR) begin
                        cmd_next.erase_sector = 1'b1;        // [RULE11] [RULE16]
                        cmd_next.program_target_address = sync2_reg.addr;
                        st_next = ST_EADD;
                    end else if (st_reg == ST_ECMD
                                 && hit(lo_addr, dbyte, `FID_UNLOCK1_ADDR,
                                        `FID_CMD_BULK)) begin
                        cmd_next.erase_bulk = 1'b1;               // [RULE11]
                    end
                end
                ST_BYP: begin
                    if (dbyte == `FID_CMD_PROG) begin
                        st_next = ST_BPROG;                       // [RULE14]
                    end else if (dbyte == `FID_CMD_ID) begin
                        st_next = ST_BRST;                        // [RULE14]
                    end
                end
                ST_BRST: begin
                    st_next = (dbyte == `FID_CMD_BYP_EXIT) ? ST_READ
                                                           : ST_BYP;
                end
                default: st_next = ST_READ;
            endcase
        end
        if (!erase_busy) begin
            susp_next = 1'b0;
        end
    end

    // Read answers
    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_go) begin
            rd_data_next = array_rd_data;                         // [RULE4]
            if (st_reg == ST_ID) begin
                if (sync2_reg.addr[7:0] == `FID_RD_ID_ADDR
                    && sel_prim) begin
                    rd_data_next = ID_VALUE;                      // [RULE9]
                end else if (sync2_reg.addr[7:0] == `FID_RD_PROT_ADDR) begin
                    rd_data_next = (|({sync2_reg.secondary_sector_select,
                                       sync2_reg.primary_sector_select}
                                      & sector_protect))
                                   ? `FID_PROT_YES : `FID_PROT_NO; // [RULE10]
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg       <= ST_READ;
            susp_reg     <= 1'b0;
            cmd_reg      <= '0;
            rd_data_reg  <= '0;
            rd_valid_reg <= 1'b0;
            mode_reg     <= 1'b1;
            byp_reg      <= 1'b0;
        end else begin
            st_reg       <= st_next;
            susp_reg     <= susp_next;
            cmd_reg      <= cmd_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_go;
            mode_reg     <= (st_next == ST_READ);
            byp_reg      <= st_next inside {ST_BYP, ST_BPROG, ST_BRST};
        end
    end

    assign cmd             = cmd_reg;
    assign rd_data         = rd_data_reg;
    assign rd_valid        = rd_valid_reg;
    assign read_array_mode = mode_reg;
    assign bypass_mode     = byp_reg;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence byp_exit_s;
        st_reg == ST_BYP && wr_go && dbyte == `FID_CMD_ID && !err_flag
        ##[1:60] st_reg == ST_BRST && wr_go && dbyte == `FID_CMD_BYP_EXIT
            && !err_flag && !tmo_exp;
    endsequence

    prog_only_sequence_a: assert property (                       // [RULE1]
        $rose(cmd_reg.prog_start) |->
            $past(st_reg, 2) inside {ST_PROG, ST_BPROG})
        else $error("program issued outside a program sequence");
    gap_abort_a: assert property (                                // [RULE3]
        tmo_exp && pending(st_reg) && !err_flag |=>
            st_reg inside {ST_READ, ST_BYP})
        else $error("timeout did not abort decoding");
    array_read_a: assert property (                               // [RULE4]
        rd_go && st_reg == ST_READ |=>
            rd_valid_reg && rd_data_reg == $past(array_rd_data))
        else $error("read array data wrong");
    unlock_order_a: assert property (                             // [RULE5]
        st_reg == ST_U2 |-> $past(st_reg) inside {ST_U1, ST_U2})
        else $error("second unlock without first");
    route_select_a: assert property (                             // [RULE7]
        wr_go |=> cmd_reg.to_secondary == !$past(sel_prim))
        else $error("instruction routed to wrong array");
    id_read_a: assert property (                                  // [RULE9]
        rd_go && st_reg == ST_ID && sel_prim
        && sync2_reg.addr[7:0] == `FID_RD_ID_ADDR |=>
            rd_data_reg == ID_VALUE)
        else $error("identifier not returned");
    prot_read_a: assert property (                                // [RULE10]
        rd_go && st_reg == ST_ID
        && sync2_reg.addr[7:0] == `FID_RD_PROT_ADDR |=>
            rd_data_reg inside {`FID_PROT_YES, `FID_PROT_NO})
        else $error("protection status malformed");
    erase_window_a: assert property (                             // [RULE16]
        win_exp && st_reg == ST_EADD && !err_flag && !wr_go |=>
            st_reg == ST_READ)
        else $error("erase window did not close");
    id_hold_a: assert property (                                  // [RULE17]
        st_reg == ST_ID && !err_flag
        && !(wr_go && dbyte == `FID_CMD_RESET) |=> st_reg == ST_ID)
        else $error("identifier mode left without reset");
    bypass_exit_a: assert property (                              // [RULE14]
        byp_exit_s |=> st_reg == ST_READ && !byp_reg ##1 mode_reg)
        else $error("bypass exit sequence failed");

endmodule : fid_decoder

// file: fid_host_model.sv
// Host bus model: drives write and read cycles on the decoder pins.
// Assumes the caller sets pace for the idle gap after each cycle.
module fid_host_model
    import fid_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Bus pins
    output fid_pins_t bus_pins
);
    timeunit 1ns;
    timeprecision 100ps;

    int pace = 8;

    initial bus_pins = '{wr_n: 1'b1, rd_n: 1'b1, default: '0};

    task automatic cycle(input logic [15:0] a, input logic [15:0] d,
                         input logic [7:0] ps, input logic [3:0] ss,
                         input logic is_wr);
        @(posedge core_clk);
        bus_pins.addr                    <= a;
        bus_pins.data                    <= d;
        bus_pins.primary_sector_select   <= ps;
        bus_pins.secondary_sector_select <= ss;
        repeat (2) @(posedge core_clk);
        if (is_wr) begin
            bus_pins.wr_n <= 1'b0;
        end else begin
            bus_pins.rd_n <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        bus_pins.wr_n <= 1'b1;
        bus_pins.rd_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        // Released address and data lines show the inverse of their last value; sector selects go to zero
        bus_pins.addr                    <= ~a;
        bus_pins.data                    <= ~d;
        bus_pins.primary_sector_select   <= '0;
        bus_pins.secondary_sector_select <= '0;
        repeat (pace) @(posedge core_clk);
    endtask : cycle
endmodule : fid_host_model

// file: flash_instruction_decoder_tb_top.sv
// Testbench of the Flash instruction decoder with a host bus model.
// Assumes short timeout and erase window counts for simulation.
module flash_instruction_decoder_tb_top
    import fid_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int          TMO    = 20;
    localparam int          WIN    = 30;
    localparam logic [15:0] ID_VAL = 16'h00c3; // Arbitrary value

    logic        core_clk       = 1'b0;
    logic        rst_n          = 1'b0;
    logic [15:0] array_rd_data  = '0;
    logic [11:0] sector_protect = '0;
    logic        erase_busy     = 1'b0;
    logic        err_flag       = 1'b0;
    logic [7:0]  psel           = 8'h01;
    logic [3:0]  ssel           = 4'h0;
    fid_pins_t   bus_pins;
    fid_cmd_t    cmd;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        read_array_mode;
    logic        bypass_mode;
    logic [5:0]  pv;
    int          cnt[6] = '{default: 0};
    int          base[6];
    int          bad_count = 0;
    int          cmp_count = 0;

    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) array_rd_data <= ~bus_pins.addr;
    assign pv = {rd_valid, cmd.resume, cmd.suspend, cmd.erase_bulk,
                 cmd.erase_sector, cmd.prog_start};
    always @(posedge core_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (pv[i] === 1'b1) cnt[i]++;
        end
    end

    fid_host_model host (.core_clk(core_clk), .bus_pins(bus_pins));

    fid_decoder #(.TIMEOUT_CYC(TMO), .ERASE_WIN_CYC(WIN), .ID_VALUE(ID_VAL))
    uut (.core_clk(core_clk), .rst_n(rst_n), .bus_pins(bus_pins),
         .array_rd_data(array_rd_data), .sector_protect(sector_protect),
         .erase_busy(erase_busy), .err_flag(err_flag), .cmd(cmd),
         .rd_data(rd_data), .rd_valid(rd_valid),
         .read_array_mode(read_array_mode), .bypass_mode(bypass_mode));

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        host.cycle(a, d, psel, ssel, 1'b1);
    endtask : wr
    task automatic rd(input logic [15:0] a);
        host.cycle(a, 16'h0000, psel, ssel, 1'b0);
    endtask : rd
    task automatic unlock();
        wr(16'h3aaa, 16'h00aa);
        wr(16'hc554, 16'h0055);
    endtask : unlock
    task automatic snap();
        base = cnt;
    endtask : snap
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_cnt(input int i, input int exp);
        cmp_count++;
        if (cnt[i] - base[i] != exp) begin
            bad_count++;
            $display("[FAIL] %0t pulse %0d count %0d expected %0d",
                     $time, i, cnt[i] - base[i], exp);
        end
    endtask : chk_cnt
    task automatic results();
        $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic t_plain();
        snap();
        chk_bit(read_array_mode, 1'b1);
        chk_bit(bypass_mode, 1'b0);
        wr(16'h0123, 16'h4567);
        chk_cnt(0, 0);
        rd(16'h0123);
        chk_word(rd_data, ~16'h0123);
        chk_cnt(5, 1);
    endtask : t_plain
    task automatic t_prog(input logic [7:0] ps, input logic [3:0] ss);
        psel = ps;
        ssel = ss;
        snap();
        unlock();
        wr(16'h5aaa, 16'h00a0);
        chk_bit(read_array_mode, 1'b0);
        wr(16'h1236, 16'hbeef);
        chk_cnt(0, 1);
        chk_word(cmd.program_target_address, 16'h1236);
        chk_word(cmd.program_word_value, 16'hbeef);
        chk_bit(cmd.to_secondary, ss != 4'h0);
        chk_word({4'h0, cmd.secondary_sector_select,
                  cmd.primary_sector_select}, {4'h0, ss, ps});
        chk_bit(read_array_mode, 1'b1);
        psel = 8'h01;
        ssel = 4'h0;
    endtask : t_prog
    task automatic t_bad();
        snap();
        wr(16'h0aaa, 16'h00aa);
        wr(16'h0555, 16'h0055);
        chk_bit(read_array_mode, 1'b1);
        wr(16'h0aaa, 16'h00a0);
        wr(16'h0100, 16'h1111);
        wr(16'h0aaa, 16'h00aa);
        psel = 8'h00;
        wr(16'h0554, 16'h0055);
        psel = 8'h01;
        wr(16'h0aaa, 16'h00a0);
        wr(16'h0100, 16'h2222);
        chk_cnt(0, 0);
        unlock();
        wr(16'h0aaa, 16'h0077);
        chk_bit(read_array_mode, 1'b1);
        unlock();
        host.pace = TMO + 10;
        wr(16'h0aaa, 16'h00a0);
        host.pace = 8;
        chk_bit(read_array_mode, 1'b1);
        wr(16'h0100, 16'h3333);
        chk_cnt(0, 0);
    endtask : t_bad
    task automatic t_id();
        unlock();
        wr(16'h0aaa, 16'h0090);
        rd(16'hf002);
        chk_word(rd_data, ID_VAL);
        sector_protect <= 12'h008;
        psel = 8'h08;
        rd(16'h0004);
        chk_word(rd_data, 16'h0001);
        psel = 8'h04;
        rd(16'h0004);
        chk_word(rd_data, 16'h0000);
        psel = 8'h00;
        ssel = 4'h2;
        rd(16'hf002);
        chk_word(rd_data, ~16'hf002);
        ssel = 4'h0;
        psel = 8'h04;
        chk_bit(read_array_mode, 1'b0);
        wr(16'h7777, 16'h00f0);
        chk_bit(read_array_mode, 1'b1);
        rd(16'h0004);
        chk_word(rd_data, ~16'h0004);
        psel = 8'h01;
    endtask : t_id
    task automatic t_erase();
        snap();
        psel = 8'h10;
        unlock();
        wr(16'h0aaa, 16'h0080);
        unlock();
        wr(16'h4100, 16'h0030);
        chk_cnt(1, 1);
        chk_word(cmd.program_target_address, 16'h4100);
        host.pace = WIN + 10;
        wr(16'h4200, 16'h0030);
        host.pace = 8;
        chk_cnt(1, 2);
        wr(16'h4300, 16'h0030);
        chk_cnt(1, 2);
        chk_cnt(4, 0);
        unlock();
        wr(16'h0aaa, 16'h0080);
        unlock();
        wr(16'h0aaa, 16'h0010);
        chk_cnt(2, 1);
        psel = 8'h01;
    endtask : t_erase
    task automatic t_susp();
        snap();
        wr(16'h0321, 16'h00b0);
        chk_cnt(3, 0);
        erase_busy <= 1'b1;
        wr(16'h0321, 16'h00b0);
        chk_cnt(3, 1);
        wr(16'h0654, 16'h0030);
        chk_cnt(4, 1);
        erase_busy <= 1'b0;
    endtask : t_susp
    task automatic t_byp();
        snap();
        unlock();
        wr(16'h0aaa, 16'h0020);
        chk_bit(bypass_mode, 1'b1);
        wr(16'h0999, 16'h00a0);
        wr(16'h0246, 16'h1357);
        chk_cnt(0, 1);
        chk_word(cmd.program_target_address, 16'h0246);
        chk_bit(bypass_mode, 1'b1);
        wr(16'h0888, 16'h0090);
        wr(16'h0777, 16'h0000);
        chk_bit(bypass_mode, 1'b0);
        chk_bit(read_array_mode, 1'b1);
    endtask : t_byp
    task automatic t_err();
        err_flag <= 1'b1;
        repeat (4) @(posedge core_clk);
        err_flag <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk_bit(read_array_mode, 1'b0);
        wr(16'h0123, 16'h00f0);
        chk_bit(read_array_mode, 1'b1);
    endtask : t_err

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        results();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_plain();
        t_prog(8'h20, 4'h0);
        t_prog(8'h00, 4'h4);
        t_bad();
        t_id();
        t_erase();
        t_susp();
        t_byp();
        t_err();
        results();
    end
endmodule : flash_instruction_decoder_tb_top
